// *** common/link_mode_pkg.sv ***
// shared constants for the link mode and power control block
package link_mode_pkg;

  // three-level strap encodings after sampling
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_MID  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;

  // decoded field values
  localparam logic SEL_UART     = 1'h0;
  localparam logic SEL_I2C      = 1'h1;
  localparam logic CABLE_TP     = 1'h0;
  localparam logic CABLE_COAX   = 1'h1;

  // rates of the reverse channel in kbps
  localparam int RATE_ROBUST_KBPS = 500;
  localparam int RATE_FAST_KBPS   = 1000;
  localparam int RATE_LEGACY_KBPS = 1000;
  localparam logic [10:0] RATE_ROBUST = 11'h1f4;
  localparam logic [10:0] RATE_FAST   = 11'h3e8;
  localparam logic [10:0] RATE_LEGACY = 11'h3e8;

  // clock and blackout times
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int LOCAL_MODE_US    = 500;
  localparam int REMOTE_MODE_US   = 1920;
  localparam int RX_POWERUP_US    = 2000;
  localparam int LOCAL_MODE_CYC   = (LOCAL_MODE_US * 1000 + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;
  localparam int REMOTE_MODE_CYC  = (REMOTE_MODE_US * 1000 + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;
  localparam int RX_POWERUP_CYC   = (RX_POWERUP_US * 1000 + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;

  // sequencer states
  typedef enum logic [3:0] {
    ST_LATCH = 4'h1,
    ST_IDLE  = 4'h2,
    ST_CFG   = 4'h4,
    ST_VIDEO = 4'h8
  } link_state_t;

endpackage

// *** logic/link_mode_power_control.sv ***
// mode, strap latch, sleep and link sequencing of the serializer
`timescale 1ns/100ps
module link_mode_power_control
  import link_mode_pkg::*;
#(
  parameter int LOCAL_CYC  = LOCAL_MODE_CYC,
  parameter int REMOTE_CYC = REMOTE_MODE_CYC,
  parameter int RXPWR_CYC  = RX_POWERUP_CYC
) (
  input  wire logic       mclk_i,             // pixel or oscillator clock
  input  wire logic       rst_i,              // async reset, active high
  input  wire logic       powerdown_n_i,      // power-down pin, low active
  input  wire logic [1:0] strap_p0_i,         // strap 0 level code
  input  wire logic [1:0] strap_p1_i,         // strap 1 level code
  input  wire logic [1:0] strap_p2_i,         // strap 2 level code
  input  wire logic [1:0] strap_p3_i,         // strap 3 level code
  input  wire logic       robust_strap_pin_i, // robust mode strap
  input  wire logic [1:0] width_strap_i,      // width strap level code
  input  wire logic       app_direction_strap_i, // application direction
  input  wire logic       wr_i,               // control bit write strobe
  input  wire logic       rate_select_i,      // new rate select
  input  wire logic       spread_en_i,        // new spread enable
  input  wire logic       robust_rev_en_i,    // new robust mode bit
  input  wire logic       rev_double_rate_i,  // new double rate bit
  input  wire logic       rev_enable_pos_i,   // new pos output enable
  input  wire logic       rev_enable_neg_i,   // new neg output enable
  input  wire logic       sleep_i,            // new sleep bit
  input  wire logic       remote_wake_off_i,  // new remote wake disable
  input  wire logic       cfg_link_en_i,      // new config link enable
  input  wire logic       video_link_en_i,    // new video link enable
  input  wire logic       remote_mode_chg_i,  // receiver mode bit changed
  input  wire logic       rx_powerup_i,       // receiver came up late
  input  wire logic       wake_cmd_i,         // wake command seen on line
  input  wire logic       local_cmd_i,        // local channel command seen
  input  wire logic       link_locked_i,      // video or config link up
  input  wire logic       req_pos_i,          // channel request, pos side
  input  wire logic       req_neg_i,          // channel request, neg side
  output logic            ctrl_chan_sel_o,    // 0 uart, 1 i2c
  output logic            spread_en_o,        // spread enabled
  output logic            rate_select_o,      // 0 high rate, 1 low rate
  output logic            cable_type_o,       // 0 tp, 1 coax
  output logic            auto_launch_o,      // 1 no autostart
  output logic            edge_select_o,      // 1 falling edge
  output logic            robust_rev_en_o,    // robust mode active
  output logic            rev_double_rate_o,  // double rate bit
  output logic [10:0]     rev_rate_kbps_o,    // reverse rate in kbps
  output logic [1:0]      width_o,            // latched width strap
  output logic            rev_enable_pos_o,   // reverse link on pos output
  output logic            rev_enable_neg_o,   // reverse link on neg output
  output logic            out_pos_en_o,       // pos serial driver enable
  output logic            out_neg_en_o,       // neg serial driver enable
  output logic            asleep_o,           // device in sleep
  output logic            prot_clear_o,       // clear protection regs
  output logic            osc_clk_sel_o,      // run on internal oscillator
  output logic            video_link_o,       // video link attempting lock
  output logic            chan_ready_o,       // control channel usable
  output logic            grant_pos_o,        // channel grant, pos side: arbitrated in uart, shared in i2c
  output logic            grant_neg_o         // channel grant, neg side, coax only: arbitrated in uart, shared in i2c
);

  logic       pd_n;
  logic [1:0] s0;
  logic [1:0] s1;
  logic [1:0] s2;
  logic [1:0] s3;
  logic       rstrap;
  logic [1:0] wstrap;

  pin_sync3 #(.W(12)) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    ({powerdown_n_i, strap_p3_i, strap_p2_i, strap_p1_i,
              strap_p0_i, robust_strap_pin_i, width_strap_i}),
    .q_o    ({pd_n, s3, s2, s1, s0, rstrap, wstrap})
  );

  function automatic logic is_mid(input logic [1:0] l);
    return l == LVL_MID;
  endfunction

  function automatic logic is_high(input logic [1:0] l);
    return l == LVL_HIGH;
  endfunction

  link_state_t state_r;
  link_state_t state_nxt;
  logic        in_pd;
  logic        sleep_r;
  logic        wake_off_r;
  logic        pos_en_r;
  logic        neg_en_r;
  logic        cfg_en_r;
  logic        vid_en_r;
  logic        robust_r;
  logic        dbl_r;
  logic        owner_r;
  logic        busy_r;
  logic [17:0] black_r;
  logic        wake_ok;

  // power-down holds everything in reset; strap latch on release
  assign in_pd = !pd_n;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_LATCH: state_nxt = ST_IDLE;
      ST_IDLE: begin
        if (vid_en_r) begin
          state_nxt = ST_VIDEO;
        end else if (cfg_en_r) begin
          state_nxt = ST_CFG;
        end
      end
      ST_CFG: begin
        if (vid_en_r) begin
          state_nxt = ST_VIDEO;
        end else if (!cfg_en_r) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_VIDEO: begin
        if (!vid_en_r) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_LATCH;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_LATCH;
    end else if (in_pd) begin
      state_r <= ST_LATCH;
    end else begin
      state_r <= state_nxt;
    end
  end

  // strap-derived fields, latched in the first cycle after power-down
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_chan_sel_o <= SEL_UART;
      spread_en_o     <= 1'h0;
      rate_select_o   <= 1'h0;
      cable_type_o    <= CABLE_TP;
      auto_launch_o   <= 1'h0;
      edge_select_o   <= 1'h0;
      width_o         <= LVL_LOW;
    end else if (in_pd) begin
      ctrl_chan_sel_o <= SEL_UART;
      spread_en_o     <= 1'h0;
      rate_select_o   <= 1'h0;
      cable_type_o    <= CABLE_TP;
      auto_launch_o   <= 1'h0;
      edge_select_o   <= 1'h0;
      width_o         <= LVL_LOW;
    end else if (state_r == ST_LATCH) begin
      ctrl_chan_sel_o <= is_mid(s1) || is_mid(s0);
      spread_en_o     <= is_high(s1) || (is_mid(s1) && is_high(s0));
      rate_select_o   <= is_high(s0) || (is_mid(s0) && s1 == LVL_LOW);
      cable_type_o    <= is_mid(s3) || is_mid(s2);
      auto_launch_o   <= is_high(s3) || (is_mid(s3) && is_high(s2));
      edge_select_o   <= is_high(s2) || (is_mid(s2) && s3 == LVL_LOW);
      width_o         <= wstrap;
    end else if (wr_i) begin
      rate_select_o   <= rate_select_i;
      spread_en_o     <= spread_en_i;
    end
  end

  // robust mode selection and its blackout
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      robust_r <= 1'h0;
      dbl_r    <= 1'h0;
    end else if (in_pd) begin
      robust_r <= 1'h0;
      dbl_r    <= 1'h0;
    end else if (state_r == ST_LATCH) begin
      robust_r <= rstrap;
    end else if (wr_i) begin
      robust_r <= robust_rev_en_i;
      dbl_r    <= rev_double_rate_i;
    end
  end

  assign robust_rev_en_o   = robust_r;
  assign rev_double_rate_o = dbl_r;
  assign rev_rate_kbps_o   = !robust_r ? RATE_LEGACY :
                             (dbl_r ? RATE_FAST : RATE_ROBUST);

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      black_r <= '0;
    end else if (in_pd) begin
      black_r <= '0;
    end else if (wr_i && robust_rev_en_i != robust_r
                 && state_r != ST_LATCH) begin
      black_r <= 18'(LOCAL_CYC);
    end else if (remote_mode_chg_i) begin
      black_r <= 18'(REMOTE_CYC);
    end else if (rx_powerup_i) begin
      black_r <= 18'(RXPWR_CYC);
    end else if (black_r != '0) begin
      black_r <= black_r - 18'h1;
    end
  end

  // software control bits
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_en_r   <= 1'h1;
      neg_en_r   <= 1'h1;
      cfg_en_r   <= 1'h0;
      vid_en_r   <= 1'h0;
      wake_off_r <= 1'h0;
    end else if (in_pd) begin
      pos_en_r   <= 1'h1;
      neg_en_r   <= 1'h1;
      cfg_en_r   <= 1'h0;
      vid_en_r   <= 1'h0;
      wake_off_r <= 1'h0;
    end else if (state_r == ST_LATCH) begin
      // autostart decoded from the straps: auto_launch_o is loaded this edge
      vid_en_r   <= !(is_high(s3) || (is_mid(s3) && is_high(s2)));
    end else if (wr_i) begin
      pos_en_r   <= rev_enable_pos_i;
      neg_en_r   <= rev_enable_neg_i;
      cfg_en_r   <= cfg_link_en_i;
      vid_en_r   <= video_link_en_i;
      wake_off_r <= remote_wake_off_i;
    end
  end

  assign rev_enable_pos_o = pos_en_r;
  assign rev_enable_neg_o = neg_en_r;

  // sleep: immediate on write, woken by local command or, on twisted pair with remote wake on, by remote command
  assign wake_ok = (local_cmd_i ||
                    (wake_cmd_i && !wake_off_r && cable_type_o == CABLE_TP));

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_r <= 1'h0;
    end else if (in_pd || state_r == ST_LATCH) begin
      sleep_r <= 1'h0;
    end else if (wr_i) begin
      sleep_r <= sleep_i;
    end else if (sleep_r && wake_ok) begin
      sleep_r <= 1'h0;
    end
  end

  assign asleep_o     = sleep_r;
  assign prot_clear_o = sleep_r || in_pd;

  // drivers: coax uses both outputs, tp only pos; off in power-down
  assign out_pos_en_o  = !in_pd && !sleep_r;
  assign out_neg_en_o  = !in_pd && !sleep_r && cable_type_o;
  assign osc_clk_sel_o = state_r == ST_CFG;
  assign video_link_o  = state_r == ST_VIDEO;

  assign chan_ready_o = (state_r == ST_CFG || state_r == ST_VIDEO)
                        && link_locked_i && black_r == '0 && !sleep_r;

  // uart arbitration between two receivers, held while busy
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      owner_r <= 1'h0;
      busy_r  <= 1'h0;
    end else if (in_pd) begin
      owner_r <= 1'h0;
      busy_r  <= 1'h0;
    end else if (!busy_r) begin
      if (req_pos_i && pos_en_r) begin
        owner_r <= 1'h0;
        busy_r  <= ctrl_chan_sel_o == SEL_UART;
      end else if (req_neg_i && neg_en_r) begin
        owner_r <= 1'h1;
        busy_r  <= ctrl_chan_sel_o == SEL_UART;
      end
    end else if (owner_r ? !req_neg_i : !req_pos_i) begin
      busy_r <= 1'h0;
    end
  end

  assign grant_pos_o = chan_ready_o && pos_en_r &&
                       (ctrl_chan_sel_o == SEL_I2C || (busy_r && !owner_r));
  assign grant_neg_o = chan_ready_o && neg_en_r && cable_type_o &&
                       (ctrl_chan_sel_o == SEL_I2C || (busy_r && owner_r));

  a_uart_single_grant: assert property (@(posedge mclk_i) disable iff (rst_i)
    ctrl_chan_sel_o == SEL_UART |-> !(grant_pos_o && grant_neg_o))
    else $error("both sides granted in uart mode");
  a_pd_tristate: assert property (@(posedge mclk_i) disable iff (rst_i)
    in_pd |-> !out_pos_en_o && !out_neg_en_o)
    else $error("driver enabled in power-down");
  a_tp_neg_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    !cable_type_o |-> !out_neg_en_o && !grant_neg_o)
    else $error("neg output used in twisted pair");
  a_sleep_now: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_i && sleep_i && !in_pd && state_r != ST_LATCH |=> asleep_o)
    else $error("sleep not entered at once");
  a_no_sleep_latch: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_r == ST_LATCH |=> !asleep_o)
    else $error("powered up asleep");
  a_local_blackout: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_i && robust_rev_en_i != robust_r && !in_pd && state_r != ST_LATCH
    |=> !chan_ready_o [*8])
    else $error("channel ready in mode blackout");
  a_video_override: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_r == ST_CFG && vid_en_r && !in_pd |=> video_link_o)
    else $error("video link did not override");
  a_ready_needs_lock: assert property (@(posedge mclk_i) disable iff (rst_i)
    chan_ready_o |-> link_locked_i && black_r == '0)
    else $error("channel ready without link");
  a_rate_robust: assert property (@(posedge mclk_i) disable iff (rst_i)
    robust_r && !dbl_r |-> rev_rate_kbps_o == RATE_ROBUST)
    else $error("robust rate wrong");
  a_strap_i2c: assert property (@(posedge mclk_i) disable iff (rst_i)
    state_r == ST_LATCH && !in_pd && is_mid(s0) |=> ctrl_chan_sel_o)
    else $error("mid strap not i2c");

endmodule

// *** logic/pin_sync3.sv ***
// three-stage synchroniser for pin inputs with agreement check
`timescale 1ns/100ps
module pin_sync3 #(
  parameter int W = 1
) (
  input  wire logic         mclk_i,   // core clock
  input  wire logic         rst_i,    // async reset, active high
  input  wire logic [W-1:0] d_i,      // raw pin level
  output logic      [W-1:0] q_o       // filtered level
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q_r <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          q_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign q_o = q_r;
endmodule

// *** sim/far_side_model.sv ***
// paired receiver and remote controller seen from the serial side
`timescale 1ns/100ps
module far_side_model #(
  parameter int LOCK_DLY = 4
) (
  input  wire logic mclk_i,            // core clock
  input  wire logic rst_i,             // async reset, active high
  input  wire logic link_on_i,         // video or config link enabled
  output logic      link_locked_o,     // receiver locked to the link
  output logic      wake_cmd_o,        // wake command on the line
  output logic      local_cmd_o,       // local controller command
  output logic      remote_mode_chg_o, // receiver robust bit changed
  output logic      rx_powerup_o,      // receiver came up late
  output logic      req_pos_o,         // request through pos output
  output logic      req_neg_o          // request through neg output
);
  int lock_cnt;

  initial begin
    {wake_cmd_o, local_cmd_o, remote_mode_chg_o, rx_powerup_o} = 4'h0;
    {req_pos_o, req_neg_o} = 2'h0;
  end

  // lock only follows some cycles after the link is switched on
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i || !link_on_i) begin
      lock_cnt      <= 0;
      link_locked_o <= 1'b0;
    end else if (lock_cnt == LOCK_DLY) begin
      link_locked_o <= 1'b1;
    end else begin
      lock_cnt <= lock_cnt + 1;
    end
  end

  // one-cycle command: 0 wake, 1 local, 2 mode change, 3 late power-up
  task automatic send(input int k);
    @(negedge mclk_i);
    case (k)
      0: wake_cmd_o = 1'b1;
      1: local_cmd_o = 1'b1;
      2: remote_mode_chg_o = 1'b1;
      default: rx_powerup_o = 1'b1;
    endcase
    @(negedge mclk_i);
    {wake_cmd_o, local_cmd_o, remote_mode_chg_o, rx_powerup_o} = 4'h0;
  endtask

  task automatic set_req(input logic p, input logic n);
    @(negedge mclk_i);
    {req_pos_o, req_neg_o} = {p, n};
  endtask
endmodule

// *** sim/link_mode_power_control_tb.sv ***
// self-checking bench for the link mode and power control block
`timescale 1ns/100ps
module link_mode_power_control_tb;
  import link_mode_pkg::*;
  localparam int LOC = 20;
  localparam int REM = 30;
  localparam int RXP = 40;
  localparam logic [9:0] BASE = 10'h031;
  logic mclk_i, rst_i, powerdown_n_i, robust_strap_pin_i, wr_i;
  logic app_direction_strap_i, link_locked_i, wake_cmd_i, local_cmd_i;
  logic remote_mode_chg_i, rx_powerup_i, req_pos_i, req_neg_i;
  logic [1:0] strap_p0_i, strap_p1_i, strap_p2_i, strap_p3_i, width_strap_i;
  logic rate_select_i, spread_en_i, robust_rev_en_i, rev_double_rate_i;
  logic rev_enable_pos_i, rev_enable_neg_i, sleep_i, remote_wake_off_i;
  logic cfg_link_en_i, video_link_en_i;
  logic ctrl_chan_sel_o, spread_en_o, rate_select_o, cable_type_o;
  logic auto_launch_o, edge_select_o, robust_rev_en_o, rev_double_rate_o;
  logic [10:0] rev_rate_kbps_o;
  logic [1:0]  width_o;
  logic rev_enable_pos_o, rev_enable_neg_o, out_pos_en_o, out_neg_en_o;
  logic asleep_o, prot_clear_o, osc_clk_sel_o, video_link_o, chan_ready_o;
  logic grant_pos_o, grant_neg_o;
  int          err_total;
  int          total_checks;
  logic [31:0] seed;
  logic [5:0]  exp6;
  wire  [5:0]  straps_seen = {ctrl_chan_sel_o, spread_en_o, rate_select_o,
                              cable_type_o, auto_launch_o, edge_select_o};

  link_mode_power_control #(.LOCAL_CYC(LOC), .REMOTE_CYC(REM),
    .RXPWR_CYC(RXP)) DUT (
    .mclk_i, .rst_i, .powerdown_n_i, .strap_p0_i, .strap_p1_i, .strap_p2_i,
    .strap_p3_i, .robust_strap_pin_i, .width_strap_i, .app_direction_strap_i,
    .wr_i, .rate_select_i, .spread_en_i, .robust_rev_en_i, .rev_double_rate_i,
    .rev_enable_pos_i, .rev_enable_neg_i, .sleep_i, .remote_wake_off_i,
    .cfg_link_en_i, .video_link_en_i, .remote_mode_chg_i, .rx_powerup_i,
    .wake_cmd_i, .local_cmd_i, .link_locked_i, .req_pos_i, .req_neg_i,
    .ctrl_chan_sel_o, .spread_en_o, .rate_select_o, .cable_type_o,
    .auto_launch_o, .edge_select_o, .robust_rev_en_o, .rev_double_rate_o,
    .rev_rate_kbps_o, .width_o, .rev_enable_pos_o, .rev_enable_neg_o,
    .out_pos_en_o, .out_neg_en_o, .asleep_o, .prot_clear_o, .osc_clk_sel_o,
    .video_link_o, .chan_ready_o, .grant_pos_o, .grant_neg_o);

  far_side_model #(.LOCK_DLY(4)) far (
    .mclk_i, .rst_i, .link_on_i(video_link_o | osc_clk_sel_o),
    .link_locked_o(link_locked_i), .wake_cmd_o(wake_cmd_i),
    .local_cmd_o(local_cmd_i), .remote_mode_chg_o(remote_mode_chg_i),
    .rx_powerup_o(rx_powerup_i), .req_pos_o(req_pos_i),
    .req_neg_o(req_neg_i));

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  function automatic logic [1:0] rnd3();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return 2'(seed % 3);
  endfunction

  // {sel, spread, rate, cable, autostart off, falling edge}
  function automatic logic [5:0] strap_exp(input logic [1:0] a0, a1, a2, a3);
    strap_exp[5] = (a1 == LVL_MID) || (a0 == LVL_MID);
    strap_exp[4] = (a1 == LVL_HIGH) || (a1 == LVL_MID && a0 == LVL_HIGH);
    strap_exp[3] = (a0 == LVL_HIGH) || (a1 == LVL_LOW && a0 == LVL_MID);
    strap_exp[2] = (a3 == LVL_MID) || (a2 == LVL_MID);
    strap_exp[1] = (a3 == LVL_HIGH) || (a3 == LVL_MID && a2 == LVL_HIGH);
    strap_exp[0] = (a2 == LVL_HIGH) || (a2 == LVL_MID && a3 == LVL_LOW);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [9:0] b);
    @(negedge mclk_i);
    wr_i = 1'b1;
    {rate_select_i, spread_en_i, robust_rev_en_i, rev_double_rate_i,
     rev_enable_pos_i, rev_enable_neg_i, sleep_i, remote_wake_off_i,
     cfg_link_en_i, video_link_en_i} = b;
    @(negedge mclk_i);
    wr_i = 1'b0;
  endtask

  // power-down, new strap levels, release and compare the latched values
  task automatic pcycle(input logic [1:0] a0, a1, a2, a3, w,
                        input logic rb);
    @(negedge mclk_i);
    powerdown_n_i = 1'b0;
    {strap_p0_i, strap_p1_i, strap_p2_i, strap_p3_i} = {a0, a1, a2, a3};
    width_strap_i = w;
    robust_strap_pin_i = rb;
    repeat (5) @(negedge mclk_i);
    check({out_pos_en_o, out_neg_en_o, rate_select_o, prot_clear_o},
          4'h1);
    powerdown_n_i = 1'b1;
    repeat (8) @(negedge mclk_i);
    exp6 = strap_exp(a0, a1, a2, a3);
    check(straps_seen, exp6);
    check({robust_rev_en_o, width_o}, {rb, w});
    check(rev_rate_kbps_o, rb ? RATE_ROBUST : RATE_LEGACY);
    check({video_link_o, asleep_o}, {!exp6[1], 1'b0});
    repeat (6) @(negedge mclk_i);
  endtask

  task automatic gap(input int cyc);
    repeat (cyc - 5) @(negedge mclk_i);
    check(chan_ready_o, 1'b0);
    repeat (10) @(negedge mclk_i);
    check(chan_ready_o, 1'b1);
  endtask

  task automatic try_wake(input logic [9:0] b, input int k, input logic e);
    wr(b);
    far.send(k);
    repeat (2) @(negedge mclk_i);
    check(asleep_o, e);
  endtask

  task automatic grants(input logic p, n, input logic [1:0] e);
    far.set_req(p, n);
    repeat (2) @(negedge mclk_i);
    check({grant_pos_o, grant_neg_o}, e);
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    test_done();
  end

  initial begin
    seed = 32'h8536;
    err_total = 0;
    total_checks = 0;
    rst_i = 1'b1;
    powerdown_n_i = 1'b1;
    app_direction_strap_i = 1'b0;
    {strap_p0_i, strap_p1_i, strap_p2_i, strap_p3_i} = 8'h0;
    width_strap_i = 2'h0;
    robust_strap_pin_i = 1'b0;
    wr_i = 1'b0;
    {rate_select_i, spread_en_i, robust_rev_en_i, rev_double_rate_i,
     rev_enable_pos_i, rev_enable_neg_i, sleep_i, remote_wake_off_i,
     cfg_link_en_i, video_link_en_i} = BASE;
    repeat (5) @(negedge mclk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 9; i++)
      pcycle(2'(i % 3), 2'(i / 3), 2'((8 - i) % 3), 2'((8 - i) / 3),
             2'(i % 3), i[0]);
    repeat (6) pcycle(rnd3(), rnd3(), rnd3(), rnd3(), rnd3(), seed[4]);
    // coax splitter in uart mode
    pcycle(LVL_LOW, LVL_LOW, LVL_LOW, LVL_MID, LVL_LOW, 1'b0);
    check({chan_ready_o, out_pos_en_o, out_neg_en_o}, 3'h7);
    grants(1'b1, 1'b1, 2'h2);
    grants(1'b0, 1'b1, 2'h1);
    grants(1'b1, 1'b1, 2'h1);
    far.set_req(1'b0, 1'b0);
    wr(BASE | 10'h008);
    check({asleep_o, out_pos_en_o, chan_ready_o, prot_clear_o, straps_seen},
          {4'h9, exp6});
    try_wake(BASE | 10'h008, 0, 1'b1);
    try_wake(BASE | 10'h008, 1, 1'b0);
    // twisted pair, remote wake on and off
    pcycle(LVL_LOW, LVL_LOW, LVL_LOW, LVL_LOW, LVL_LOW, 1'b0);
    try_wake(BASE | 10'h008, 0, 1'b0);
    try_wake(BASE | 10'h00c, 0, 1'b1);
    try_wake(BASE | 10'h00c, 1, 1'b0);
    wr(BASE | 10'h300);
    check({rate_select_o, spread_en_o}, 2'h3);
    // i2c coax: per-output enables, robust mode and blackouts
    pcycle(LVL_MID, LVL_LOW, LVL_LOW, LVL_MID, LVL_HIGH, 1'b0);
    grants(1'b1, 1'b1, 2'h3);
    wr(BASE & ~10'h020);
    check({rev_enable_pos_o, rev_enable_neg_o, grant_pos_o, grant_neg_o},
          4'h5);
    far.set_req(1'b0, 1'b0);
    wr(BASE | 10'h080);
    check({robust_rev_en_o, rev_rate_kbps_o}, {1'b1, RATE_ROBUST});
    gap(LOC);
    wr(BASE | 10'h0c0);
    check({rev_double_rate_o, rev_rate_kbps_o}, {1'b1, RATE_FAST});
    wr(BASE);
    check({robust_rev_en_o, rev_rate_kbps_o}, {1'b0, RATE_LEGACY});
    gap(LOC);
    far.send(2);
    gap(REM);
    far.send(3);
    gap(RXP);
    // no autostart: configuration link, then video link
    pcycle(LVL_LOW, LVL_LOW, LVL_LOW, LVL_HIGH, LVL_LOW, 1'b0);
    check({video_link_o, osc_clk_sel_o, chan_ready_o}, 3'h0);
    wr(10'h032);
    repeat (6) @(negedge mclk_i);
    check({video_link_o, osc_clk_sel_o, chan_ready_o}, 3'h3);
    wr(10'h033);
    @(negedge mclk_i);
    check({video_link_o, osc_clk_sel_o, chan_ready_o}, 3'h5);
    test_done();
  end
endmodule
